// >>> logic/dts_pkg.sv
// Constants, enums and carrier structs for the training and sync generator.
// Assumes one 20 MHz system clock; all users import the whole package.
package dts_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 50;
	// ----------------------------------------
	// Training format
	// ----------------------------------------
	localparam int SYM_LEN = 32;
	localparam logic [6:0] SYM_LAST = 7'(SYM_LEN - 1);
	localparam logic [6:0] GI_IND_SHORT = 7'(SYM_LEN / 4);
	localparam logic [6:0] GI_IND_LONG = 7'(SYM_LEN / 2);
	localparam logic [6:0] GI_COM_SHORT = 7'(SYM_LEN * 3 / 8);
	localparam logic [6:0] GI_COM_LONG = 7'(SYM_LEN * 5 / 8);
	localparam logic [4:0] NUM_CORE = 5'h0C;
	localparam logic [3:0] CORE_DL = 4'h1;
	localparam logic [3:0] CORE_UL = 4'h2;
	localparam logic [5:0] OFS_ONE = 6'h01;
	localparam logic [5:0] OFS_BASE = 6'h02;
	localparam logic [4:0] OFS_STEP = 5'h04;
	// ----------------------------------------
	// Synchronization signals
	// ----------------------------------------
	localparam int ZC_HALF = 31;
	localparam int ZC_MOD = 126;
	localparam int SEQ_LEN = 62;
	localparam int RSV = 5;
	localparam logic [6:0] ZC_LAST = 7'(SEQ_LEN + 2 * RSV - 1);
	localparam logic [6:0] SSS_LAST = 7'(SEQ_LEN - 1);
	localparam logic [5:0] ZC_ROOT0 = 6'h19;
	localparam logic [5:0] ZC_ROOT1 = 6'h1D;
	localparam logic [5:0] ZC_ROOT2 = 6'h22;
	localparam logic [5:0] MSEQ_LEN = 6'h1F;
	localparam logic [4:0] MSEQ_SEED = 5'h10;
	localparam logic [5:0] C1_SHIFT = 6'h03;
	localparam logic [4:0] Z_MASK = 5'h07;
	localparam logic [2:0] PSS_SYM = 3'h2;
	localparam logic [2:0] SSS_SYM = 3'h6;
	localparam int FIFO_DEPTH = 8;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {FMT_INDIV, FMT_COMMON, FMT_PSS, FMT_SSS} dts_fmt_t;
	typedef struct packed {
		dts_fmt_t fmt;
		logic uplink;
		logic guard_long;
		logic [9:0] base_station_identifier;
		logic mimo;
		logic sdma;
		logic [2:0] stream;
		logic [4:0] nch;
		logic [4:0] chan;
		logic [1:0] nid2;
		logic [4:0] m0;
		logic [4:0] m1;
		logic slot5;
		logic [1:0] port;
		logic low_mcs;
		logic extra_boost;
	} dts_cfg_t;
	typedef struct packed {
		dts_fmt_t fmt;
		logic zero;
		logic [1:0] boost;
		logic [2:0] sym;
		logic [1:0] port;
		logic signed [7:0] kofs;
		logic [4:0] addr;
		logic [6:0] val;
	} dts_samp_t;
endpackage

// >>> logic/dts_fifo.sv
// Sample FIFO with a registered output stage.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/1ns
module dts_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	// Handshake terms
	assign in_ready = count != CNT_FULL;
	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);

	// Storage array
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wptr <= (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == PTR_LAST) ? '0 : rptr + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// Output register stage
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (pop) begin
			out_data <= mem[rptr];
			out_valid <= 1'b1;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule // dts_fifo

// >>> logic/dts_mseq.sv
// Length-31 base m-sequence, all 31 bits at once.
// Pure combinational constant; no clock needed.
`timescale 1ns/1ns
module dts_mseq
	import dts_pkg::*;
(
	output logic [30:0] x_seq
);
	// Seed with four zeros then a one
	assign x_seq[4:0] = MSEQ_SEED;
	// Recursion x(i+5) = x(i+3) xor x(i)
	for (genvar i = 0; i < 26; i++) begin : g_rec
		assign x_seq[i+5] = x_seq[i+3] ^ x_seq[i];
	end
endmodule // dts_mseq

// >>> logic/dts_gen.sv
// Downlink training format and synchronization sequence generator.
// Assumes synchronous inputs, a consumer that drains samples with ready.
// Operation
// - Individual guard copies quarter or half symbol
// - Individual uses first training symbol only
// - Common guard copies 3/8 or 5/8 of second
// - Common sends first then second training symbol
// - Core sequence rotated by offset sample
// - Offset number one means no rotation
// - Training samples boosted, extra only low MCS
// - Index is core plus twelve times offset-1
// - Common core 1 downlink, 2 uplink, offset 1
// - SISO core: low five bits mod 12, plus 1
// - Offset (B+m) mod (n-1) plus 2
// - MIMO core adds stream minus one
// - Stream forced to one unless SDMA
// - PSS 62 ZC samples, shifted term from 31 up
// - Root 25, 29, 34 for identity 0..2
// - PSS at -31, third symbol, slots 1, 6
// - Five reserved carriers each side carry nothing
// - SSS interleaves two sequences, swapped slot 5
// - m-sequence recursion and seed 00001
// - Scramblers shifted by identity and identity+3
// - Odd scrambler shift is index mod 8
// - SSS reuses PSS port, last symbol, centred
`timescale 1ns/1ns
module dts_gen
	import dts_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic start,
	input dts_cfg_t cfg,
	output logic busy,
	output logic [8:0] train_index,
	output logic [3:0] core_num,
	output logic [5:0] offset_num,
	output dts_samp_t samp,
	output logic samp_valid,
	input wire logic samp_ready
);
	typedef enum logic [2:0] {S_IDLE, S_GUARD, S_SYM1, S_SYM2, S_ZC, S_SSS} dts_state_t;
	dts_state_t state;
	dts_cfg_t cur;
	logic [6:0] cnt;
	logic [4:0] shift;
	logic [1:0] pss_port;
	logic [30:0] x_seq;
	logic fifo_ready;
	logic push;
	logic take;
	logic last;
	logic [6:0] glen;
	dts_samp_t next_samp;
	logic [3:0] next_core;
	logic [5:0] next_ofs;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Wrap an index below 62 into 0..30
	function automatic logic [4:0] wrap31(input logic [5:0] a);
		return (a >= MSEQ_LEN) ? 5'(a - MSEQ_LEN) : a[4:0];
	endfunction

	// Bit of the m-sequence after a cyclic shift
	function automatic logic mbit(input logic [30:0] v, input logic [4:0] n,
		input logic [5:0] sh);
		return v[wrap31(6'(n) + sh)];
	endfunction

	// Zadoff-Chu root per physical identity
	function automatic logic [5:0] zc_root(input logic [1:0] id);
		unique case (id)
			2'h0: return ZC_ROOT0;
			2'h1: return ZC_ROOT1;
			default: return ZC_ROOT2;
		endcase
	endfunction

	// ----------------------------------------
	// Training index arithmetic
	// ----------------------------------------
	always_comb begin
		logic [5:0] a_part;
		logic [5:0] b_part;
		logic [2:0] kk;
		a_part = 6'(cfg.base_station_identifier[4:0]);
		b_part = 6'(cfg.base_station_identifier[9:5]) + 6'(cfg.chan);
		kk = (cfg.mimo && cfg.sdma) ? cfg.stream : 3'h1;
		if (cfg.fmt == FMT_COMMON) begin
			next_core = cfg.uplink ? CORE_UL : CORE_DL;
			next_ofs = OFS_ONE;
		end else begin
			// Core number, stream term is one in SISO
			next_core = 4'(((a_part + 6'(kk) - 6'h01) % 6'(NUM_CORE)) + 6'h01);
			if (cfg.nch < 5'h02) begin
				next_ofs = OFS_ONE;
			end else begin
				next_ofs = (b_part % 6'(cfg.nch - 5'h01)) + OFS_BASE;
			end
		end
	end

	// Latch request and training parameters
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cur <= '0;
			core_num <= CORE_DL;
			offset_num <= OFS_ONE;
			train_index <= 9'h001;
			shift <= '0;
		end else if (take) begin
			cur <= cfg;
			core_num <= next_core;
			offset_num <= next_ofs;
			train_index <= 9'(next_core) + 9'(next_ofs - 6'h01) * 9'(NUM_CORE);
			shift <= 5'(next_ofs - 6'h01) * OFS_STEP;
		end
	end

	// Antenna port of the last primary sync in this half frame
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pss_port <= '0;
		end else if (take && cfg.fmt == FMT_PSS) begin
			pss_port <= cfg.port;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign take = start && state == S_IDLE;
	assign push = state != S_IDLE && fifo_ready;

	// Guard length by format and option
	always_comb begin
		if (cur.fmt == FMT_COMMON) begin
			glen = cur.guard_long ? GI_COM_LONG : GI_COM_SHORT;
		end else begin
			glen = cur.guard_long ? GI_IND_LONG : GI_IND_SHORT;
		end
	end

	// Last sample of the current phase
	always_comb begin
		unique case (state)
			S_GUARD: last = cnt == glen - 7'h01;
			S_SYM1, S_SYM2: last = cnt == SYM_LAST;
			S_ZC: last = cnt == ZC_LAST;
			S_SSS: last = cnt == SSS_LAST;
			default: last = 1'b0;
		endcase
	end

	// State and sample counter
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
			cnt <= '0;
		end else if (take) begin
			cnt <= '0;
			unique case (cfg.fmt)
				FMT_INDIV, FMT_COMMON: state <= S_GUARD;
				FMT_PSS: state <= S_ZC;
				FMT_SSS: state <= S_SSS;
			endcase
		end else if (push) begin
			cnt <= last ? '0 : cnt + 7'h01;
			if (last) begin
				unique case (state)
					S_GUARD: state <= S_SYM1;
					S_SYM1: state <= (cur.fmt == FMT_COMMON) ? S_SYM2 : S_IDLE;
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Busy flag
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
		end else begin
			busy <= take || (state != S_IDLE && !(push && last && state != S_GUARD
				&& !(state == S_SYM1 && cur.fmt == FMT_COMMON)));
		end
	end

	// ----------------------------------------
	// Sample forming
	// ----------------------------------------
	dts_mseq u_mseq (
		.x_seq(x_seq)
	);

	always_comb begin
		int n;
		int m;
		int prod;
		logic [4:0] h;
		logic [4:0] raw;
		logic s0;
		logic s1;
		logic c0;
		logic c1;
		logic z0;
		logic z1;
		n = int'(cnt) - RSV;
		m = (n < ZC_HALF) ? n : n + 1;
		prod = int'(zc_root(cur.nid2)) * m * (m + 1);
		h = 5'(cnt >> 1);
		raw = 5'(cnt);
		s0 = mbit(x_seq, h, 6'(cur.m0));
		s1 = mbit(x_seq, h, 6'(cur.m1));
		c0 = mbit(x_seq, h, 6'(cur.nid2));
		c1 = mbit(x_seq, h, 6'(cur.nid2) + C1_SHIFT);
		z0 = mbit(x_seq, h, 6'(cur.m0 & Z_MASK));
		z1 = mbit(x_seq, h, 6'(cur.m1 & Z_MASK));
		next_samp = '0;
		next_samp.fmt = cur.fmt;
		next_samp.port = cur.port;
		unique case (state)
			S_GUARD: begin
				// Tail of the symbol copied ahead
				raw = 5'(7'(SYM_LEN) - glen + cnt);
				next_samp.sym = (cur.fmt == FMT_COMMON) ? 3'h1 : 3'h0;
			end
			S_SYM2: begin
				next_samp.sym = 3'h1;
			end
			S_ZC: begin
				next_samp.sym = PSS_SYM;
				next_samp.kofs = 8'(n - ZC_HALF);
				next_samp.zero = (n < 0) || (n >= SEQ_LEN);
				next_samp.val = next_samp.zero ? 7'h00 : 7'(prod % ZC_MOD);
			end
			S_SSS: begin
				next_samp.sym = SSS_SYM;
				next_samp.port = pss_port;
				next_samp.kofs = 8'(int'(cnt) - ZC_HALF);
				// Sign bit, 1 means -1
				if (!cnt[0]) begin
					next_samp.val = 7'(cur.slot5 ? (s1 ^ c0) : (s0 ^ c0));
				end else begin
					next_samp.val = 7'(cur.slot5 ? (s0 ^ c1 ^ z1) : (s1 ^ c1 ^ z0));
				end
			end
			default: begin
			end
		endcase
		if (state == S_GUARD || state == S_SYM1 || state == S_SYM2) begin
			next_samp.addr = raw + shift;
			next_samp.boost = {cur.extra_boost && cur.low_mcs, 1'b1};
		end
	end

	dts_fifo #(
		.WIDTH($bits(dts_samp_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_data(next_samp),
		.in_valid(state != S_IDLE),
		.in_ready(fifo_ready),
		.out_data(samp),
		.out_valid(samp_valid),
		.out_ready(samp_ready)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_indiv_guard;
		@(posedge clk_sys) disable iff (!nrst)
		(state == S_GUARD && cur.fmt == FMT_INDIV) |-> cnt < GI_IND_LONG;
	endproperty
	a_indiv_guard: assert property (p_indiv_guard) else $error("guard too long");

	property p_indiv_single;
		@(posedge clk_sys) disable iff (!nrst)
		state == S_SYM2 |-> cur.fmt == FMT_COMMON;
	endproperty
	a_indiv_single: assert property (p_indiv_single) else $error("unexpected second symbol");

	property p_common_guard;
		@(posedge clk_sys) disable iff (!nrst)
		(push && state == S_GUARD && cur.fmt == FMT_COMMON && !cur.guard_long && cnt == 7'h00)
		|-> next_samp.addr == 5'(7'(SYM_LEN) - GI_COM_SHORT + 7'(shift));
	endproperty
	a_common_guard: assert property (p_common_guard) else $error("common guard start");

	property p_no_shift;
		@(posedge clk_sys) disable iff (!nrst)
		(take && next_ofs == OFS_ONE) |=> shift == 5'h00;
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("offset one rotated");

	property p_index;
		@(posedge clk_sys) disable iff (!nrst)
		take |=> train_index == 9'(core_num) + 9'(offset_num - 6'h01) * 9'(NUM_CORE);
	endproperty
	a_index: assert property (p_index) else $error("training index wrong");

	property p_common_core;
		@(posedge clk_sys) disable iff (!nrst)
		(take && cfg.fmt == FMT_COMMON) |=>
		core_num == ($past(cfg.uplink) ? CORE_UL : CORE_DL) && offset_num == OFS_ONE;
	endproperty
	a_common_core: assert property (p_common_core) else $error("common core wrong");

	property p_siso_core;
		@(posedge clk_sys) disable iff (!nrst)
		(take && cfg.fmt == FMT_INDIV && !cfg.mimo) |=>
		core_num == 4'(($past(cfg.base_station_identifier[4:0]) % NUM_CORE) + 5'h01);
	endproperty
	a_siso_core: assert property (p_siso_core) else $error("SISO core wrong");

	property p_reserved;
		@(posedge clk_sys) disable iff (!nrst)
		(push && state == S_ZC && (cnt < 7'(RSV) || cnt > 7'(SEQ_LEN + RSV - 1)))
		|-> next_samp.zero && next_samp.val == 7'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved carrier used");

	property p_pss_place;
		@(posedge clk_sys) disable iff (!nrst)
		(push && state == S_ZC && cnt == 7'(RSV))
		|-> next_samp.kofs == -8'sd31 && next_samp.val == 7'h00 && next_samp.sym == PSS_SYM;
	endproperty
	a_pss_place: assert property (p_pss_place) else $error("PSS placement wrong");

	property p_sss_port;
		@(posedge clk_sys) disable iff (!nrst)
		(push && state == S_SSS) |-> next_samp.port == pss_port && next_samp.sym == SSS_SYM;
	endproperty
	a_sss_port: assert property (p_sss_port) else $error("SSS port differs");

	// Extra boost never without a low-order modulation
	property p_boost;
		@(posedge clk_sys) disable iff (!nrst)
		(push && (state == S_SYM1 || state == S_SYM2))
		|-> next_samp.boost[0] && (!next_samp.boost[1] || cur.low_mcs);
	endproperty
	a_boost: assert property (p_boost) else $error("training boost wrong");
endmodule // dts_gen

// >>> sim/dts_sink.sv
// Receiver model on the sample stream; records the first 128 accepted samples since clr.
// Assumes samples arrive on samp/samp_valid and are taken with samp_ready.
`timescale 1ns/1ns
module dts_sink
	import dts_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input dts_samp_t samp,
	input wire logic samp_valid,
	output logic samp_ready,
	input wire logic slow,
	input wire logic hold,
	input wire logic clr
);
	dts_samp_t cap [0:127];
	int n_cap;
	logic [1:0] ph;
	// ----------------------------------------
	// Ready pattern: prompt, one in four, or stalled
	// ----------------------------------------
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ph <= 2'h0;
			samp_ready <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			samp_ready <= !hold && (!slow || ph == 2'h3);
		end
	end
	// Capture on each accepted transfer
	always @(posedge clk_sys) begin
		if (clr) begin
			n_cap <= 0;
		end else if (samp_valid && samp_ready && n_cap < 128) begin
			cap[n_cap] <= samp;
			n_cap <= n_cap + 1;
		end
	end
endmodule // dts_sink

// >>> sim/testbench.sv
// Self-checking bench for the training and sync generator.
// Assumes the receiver model in dts_sink; 20 MHz clock.
`timescale 1ns/1ns
module testbench;
	import dts_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic start = 1'b0;
	logic slow = 1'b0;
	logic hold = 1'b0;
	logic clr = 1'b0;
	dts_cfg_t cfg = '0;
	logic busy;
	logic [8:0] train_index;
	logic [3:0] core_num;
	logic [5:0] offset_num;
	dts_samp_t samp;
	logic samp_valid;
	logic samp_ready;
	int n_errors = 0;
	int checks_done = 0;
	bit xs [0:30];
	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial begin
		forever #(CLK_NS / 2) clk_sys = ~clk_sys;
	end
	initial begin
		#(CLK_NS * 60000);
		n_errors++;
		tally_and_finish();
	end
	dts_gen i_dts_gen (.clk_sys(clk_sys), .nrst(nrst), .start(start), .cfg(cfg), .busy(busy),
		.train_index(train_index), .core_num(core_num), .offset_num(offset_num),
		.samp(samp), .samp_valid(samp_valid), .samp_ready(samp_ready));
	dts_sink i_dts_sink (.clk_sys(clk_sys), .nrst(nrst), .samp(samp), .samp_valid(samp_valid),
		.samp_ready(samp_ready), .slow(slow), .hold(hold), .clr(clr));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Start one request, optionally stall the receiver, wait for the drain
	task automatic run(input dts_cfg_t c, input int exp_n, input bit stall);
		int k;
		dts_samp_t snap;
		@(posedge clk_sys); #1;
		cfg = c;
		start = 1'b1;
		clr = 1'b1;
		@(posedge clk_sys); #1;
		start = 1'b0;
		clr = 1'b0;
		if (stall) begin
			hold = 1'b1;
			repeat (4) @(posedge clk_sys);
			#1 snap = samp;
			repeat (30) @(posedge clk_sys);
			#1 chk("held sample", 32'(snap), 32'(samp));
			chk("stalled busy", 32'h1, {31'h0, busy});
			hold = 1'b0;
		end
		k = 0;
		while (busy !== 1'b0 && k < 3000) begin
			@(posedge clk_sys);
			k++;
		end
		repeat (60) @(posedge clk_sys);
		#1 chk("count", exp_n, i_dts_sink.n_cap);
	endtask
	task automatic chk_idx(input int core, input int ofs);
		chk("core", core, {28'h0, core_num});
		chk("offset", ofs, {26'h0, offset_num});
		chk("index", core + 12 * (ofs - 1), {23'h0, train_index});
	endtask
	// Training samples: guard from the symbol tail, then symbols, rotated by sh
	task automatic chk_train(input dts_fmt_t f, input int g, input bit two,
		input logic [1:0] bst, input int sh);
		dts_samp_t s;
		int j;
		for (int i = 0; i < i_dts_sink.n_cap; i++) begin
			s = i_dts_sink.cap[i];
			j = (i < g) ? (SYM_LEN - g + i) : (i - g);
			chk("fmt", f, {30'h0, s.fmt});
			chk("addr", (j + sh) % SYM_LEN, {27'h0, s.addr});
			chk("sym", (i < g) ? two : (j / SYM_LEN), {29'h0, s.sym});
			chk("boost", bst, {30'h0, s.boost});
		end
	endtask
	task automatic t_common();
		dts_cfg_t c;
		c = '0;
		c.fmt = FMT_COMMON;
		for (int k = 0; k < 4; k++) begin
			c.uplink = k[0];
			c.guard_long = k[1];
			run(c, (k[1] ? 20 : 12) + 2 * SYM_LEN, 1'b0);
			chk_idx(k[0] ? 2 : 1, 1);
			chk_train(FMT_COMMON, k[1] ? 20 : 12, 1'b1, 2'h1, 0);
		end
	endtask
	task automatic t_indiv();
		dts_cfg_t c;
		c = '0;
		c.fmt = FMT_INDIV;
		c.base_station_identifier = 10'h3FF;
		c.nch = 5'h01;
		c.extra_boost = 1'b1;
		run(c, 8 + SYM_LEN, 1'b0);
		chk_idx(8, 1);
		chk_train(FMT_INDIV, 8, 1'b0, 2'h1, 0);
		c.guard_long = 1'b1;
		c.low_mcs = 1'b1;
		run(c, 16 + SYM_LEN, 1'b0);
		chk_train(FMT_INDIV, 16, 1'b0, 2'h3, 0);
		c.nch = 5'h05;
		c.chan = 5'h03;
		run(c, 16 + SYM_LEN, 1'b0);
		chk_idx(8, 4);
		// Offset number 4 rotates by three offset steps
		chk_train(FMT_INDIV, 16, 1'b0, 2'h3, 3 * OFS_STEP);
	endtask
	task automatic t_mimo();
		dts_cfg_t c;
		c = '0;
		c.fmt = FMT_INDIV;
		c.mimo = 1'b1;
		c.sdma = 1'b1;
		c.stream = 3'h3;
		c.base_station_identifier = 10'h00B;
		c.nch = 5'h04;
		c.chan = 5'h02;
		run(c, 8 + SYM_LEN, 1'b0);
		chk_idx(2, 4);
		c.sdma = 1'b0;
		run(c, 8 + SYM_LEN, 1'b0);
		chk_idx(12, 4);
	endtask
	// A second start while busy must leave the first request intact
	task automatic t_refuse();
		dts_cfg_t c;
		c = '0;
		c.fmt = FMT_COMMON;
		@(posedge clk_sys); #1;
		cfg = c;
		start = 1'b1;
		@(posedge clk_sys); #1;
		cfg.uplink = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 start = 1'b0;
		repeat (200) @(posedge clk_sys);
		#1 chk_idx(1, 1);
	endtask
	task automatic t_pss();
		dts_cfg_t c;
		dts_samp_t s;
		int n;
		int u;
		c = '0;
		c.fmt = FMT_PSS;
		c.port = 2'h2;
		for (int id = 0; id < 3; id++) begin
			c.nid2 = id[1:0];
			u = (id == 0) ? 25 : (id == 1) ? 29 : 34;
			run(c, SEQ_LEN + 2 * RSV, id == 1);
			for (int i = 0; i < i_dts_sink.n_cap; i++) begin
				s = i_dts_sink.cap[i];
				n = i - RSV;
				chk("kofs", {24'h0, 8'(n - 31)}, {24'h0, s.kofs});
				chk("zero", n < 0 || n > 61, {31'h0, s.zero});
				chk("sym", 2, {29'h0, s.sym});
				chk("port", 2, {30'h0, s.port});
				chk("fmt", FMT_PSS, {30'h0, s.fmt});
				if (n >= 0 && n <= 61) chk("phase", (u * ((n < 31) ? n * (n + 1) :
					(n + 1) * (n + 2))) % 126, {25'h0, s.val});
			end
		end
	endtask
	task automatic t_sss();
		dts_cfg_t c;
		dts_samp_t s;
		int n;
		int ma;
		int mb;
		bit e;
		c = '0;
		c.fmt = FMT_SSS;
		c.nid2 = 2'h2;
		c.m0 = 5'h0B;
		c.m1 = 5'h1D;
		// Own port differs; the secondary must follow the primary's port
		c.port = 2'h1;
		slow = 1'b1;
		for (int sl = 0; sl < 2; sl++) begin
			c.slot5 = sl[0];
			ma = sl ? 29 : 11;
			mb = sl ? 11 : 29;
			run(c, SEQ_LEN, 1'b0);
			for (int i = 0; i < i_dts_sink.n_cap; i++) begin
				s = i_dts_sink.cap[i];
				n = i / 2;
				if (i % 2 == 0) e = xs[(n + ma) % 31] ^ xs[(n + 2) % 31];
				else e = xs[(n + mb) % 31] ^ xs[(n + 5) % 31] ^ xs[(n + ma % 8) % 31];
				chk("sign", e, {31'h0, s.val[0]});
				chk("kofs", {24'h0, 8'(i - 31)}, {24'h0, s.kofs});
				chk("sym", 6, {29'h0, s.sym});
				chk("port", 2, {30'h0, s.port});
			end
		end
		slow = 1'b0;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 31; i++) xs[i] = (i == 4);
		for (int i = 0; i < 26; i++) xs[i + 5] = xs[i + 3] ^ xs[i];
		repeat (20) @(posedge clk_sys);
		#1 nrst = 1'b1;
		chk_idx(1, 1);
		t_common();
		t_indiv();
		t_mimo();
		t_refuse();
		t_pss();
		t_sss();
		tally_and_finish();
	end
endmodule // testbench
